// [verilog/pwm_cfg_pkg.sv]
// package: command codes, field positions, reset values and carriers for the pwm mode/compensation bank
package pwm_cfg_pkg;

    // ------------------------------------------------------------
    // command codes and defaults
    // ------------------------------------------------------------
    localparam logic [7:0] cmd_loop_comp = 8'hD3;    // loop compensation config
    localparam logic [7:0] cmd_pwm_mode = 8'hD4;     // channel pwm mode config
    localparam logic [7:0] mode_reset = 8'hC1;       // mode power-on value
    localparam logic [7:0] comp_reset = 8'h70;       // compensation power-on value
    localparam int num_channels = 2;                 // paged channels

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int mode_bit_fccm = 0;                // conduction mode
    localparam int mode_bit_vrange = 1;              // output range 30v when 1
    localparam int mode_lsb_drv = 2;                 // gate drive select lsb
    localparam int mode_bit_rsvd = 4;                // reserved
    localparam int mode_bit_tsense = 5;              // temp sense method
    localparam int mode_bit_servo = 6;               // servo enable
    localparam int mode_bit_ilim = 7;                // current range
    localparam logic [7:0] mode_live_mask = 8'h41;   // bits changeable while on
    localparam logic [7:0] mode_mask_ch0 = 8'hEF;    // implemented bits page 0
    localparam logic [7:0] mode_mask_ch1 = 8'hE3;    // implemented bits page 1
    localparam logic [1:0] drv_code_max = 2'h2;      // highest defined drive code

    // ------------------------------------------------------------
    // decoded per-channel settings
    // ------------------------------------------------------------
    typedef struct packed {
        logic high_ilim;       // high current limit range
        logic servo_en;        // output servo active now
        logic tsense_direct;   // direct voltage temperature sense
        logic [1:0] drv_sel;   // gate drive supply code
        logic vout_low_range;  // 30v range
        logic fccm;            // effective forced continuous
        logic [2:0] gm_code;   // transconductance step
        logic [4:0] rcomp_code;// compensation resistor code
    } chan_cfg_t;

    // host write carrier
    typedef struct packed {
        logic valid;           // one-cycle write strobe
        logic page;            // addressed channel
        logic [7:0] code;      // command code
        logic [7:0] data;      // data byte
    } cfg_write_t;

endpackage

// [verilog/pwm_mode_comp_config.sv]
// module: per-channel pwm mode and loop compensation configuration registers
// Summary of operation
// - only servo (bit 6) and conduction mode (bit 0) change while on
// - locked change while on faults, drops write
// - bit 7 picks current limit range
// - bit 6 servo, never off or ramping
// - bit 5 picks temperature sense method
// - bits 3:2 gate drive, page 0 only
// - bit 1 picks 60v or 30v range
// - bit 0 discontinuous or forced continuous
// - ramping forces discontinuous operation
// - comp bits 7:5 transconductance step
// - comp bits 4:0 compensation resistor
// - mode command 0xD4, default 0xC1, paged
// - comp command 0xD3, default 0x70, paged
module pwm_mode_comp_config
    import pwm_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire cfg_write_t wr,
    input wire logic rd_page,
    input wire logic [7:0] rd_code,
    input wire logic [num_channels-1:0] chan_on,
    input wire logic [num_channels-1:0] chan_ramping,
    output logic [7:0] rd_data,
    output logic rd_hit,
    output logic comm_fault,
    output chan_cfg_t cfg_out [num_channels]
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // implemented-bit mask for a page
    function automatic logic [7:0] mode_mask(input logic page);
        mode_mask = page ? mode_mask_ch1 : mode_mask_ch0;
    endfunction

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] mode_reg [num_channels];       // pwm mode per channel
    logic [7:0] comp_reg [num_channels];       // compensation per channel
    logic [7:0] next_mode_reg [num_channels];
    logic [7:0] next_comp_reg [num_channels];
    logic next_comm_fault;                     // fault pulse next value
    logic [7:0] clean_data;                    // write data with reserved cleared
    logic [7:0] locked_diff;                   // locked bits that would change

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    always_comb begin
        // reserved bits cleared so they never count as a change
        // mask reserved bits
        clean_data = wr.data & mode_mask(wr.page);
        locked_diff = (clean_data ^ mode_reg[wr.page]) & ~mode_live_mask;
        next_comm_fault = 1'b0;
        for (int c = 0; c < num_channels; c++) begin
            next_mode_reg[c] = mode_reg[c];
            next_comp_reg[c] = comp_reg[c];
        end
        if (wr.valid) begin
            if (wr.code == cmd_pwm_mode) begin
                // reject locked change on live channel
                if (chan_on[wr.page] && (locked_diff != 8'h00)) begin
                    next_comm_fault = 1'b1;
                end else begin
                    next_mode_reg[wr.page] = clean_data;
                end
            end else if (wr.code == cmd_loop_comp) begin
                next_comp_reg[wr.page] = wr.data;
            end
        end
    end

    // register the bank
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < num_channels; c++) begin
                mode_reg[c] <= mode_reset & mode_mask(c[0]);
                comp_reg[c] <= comp_reset;
            end
            comm_fault <= 1'b0;
        end else begin
            for (int c = 0; c < num_channels; c++) begin
                mode_reg[c] <= next_mode_reg[c];
                comp_reg[c] <= next_comp_reg[c];
            end
            comm_fault <= next_comm_fault;
        end
    end

    // ------------------------------------------------------------
    // readback
    // ------------------------------------------------------------
    always_comb begin
        rd_hit = 1'b1;
        if (rd_code == cmd_pwm_mode) begin
            rd_data = mode_reg[rd_page];
        end else if (rd_code == cmd_loop_comp) begin
            rd_data = comp_reg[rd_page];
        end else begin
            rd_data = 8'h00;
            rd_hit = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // decoded settings to the analog/control side
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < num_channels; c++) begin
            cfg_out[c].high_ilim = mode_reg[c][mode_bit_ilim];
            // servo only when on and settled
            cfg_out[c].servo_en = mode_reg[c][mode_bit_servo] & chan_on[c] & ~chan_ramping[c];
            cfg_out[c].tsense_direct = mode_reg[c][mode_bit_tsense];
            // gate drive code, undefined code held at max
            if (mode_reg[c][mode_lsb_drv+:2] > drv_code_max) begin
                cfg_out[c].drv_sel = drv_code_max;
            end else begin
                cfg_out[c].drv_sel = mode_reg[c][mode_lsb_drv+:2];
            end
            cfg_out[c].vout_low_range = mode_reg[c][mode_bit_vrange];
            cfg_out[c].fccm = mode_reg[c][mode_bit_fccm] & ~chan_ramping[c];
            cfg_out[c].gm_code = comp_reg[c][7:5];
            cfg_out[c].rcomp_code = comp_reg[c][4:0];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // a mode write that tries to move a locked bit of a live channel
    sequence s_rejected_write;
        wr.valid && wr.code == cmd_pwm_mode && chan_on[wr.page] && locked_diff != 8'h00;
    endsequence

    // the fault answer: high for one cycle, then low again
    sequence s_fault_once;
        comm_fault ##1 !comm_fault;
    endsequence

    a_locked_fault: assert property (@(posedge core_clk) disable iff (rst)
        s_rejected_write |=> comm_fault && mode_reg[$past(wr.page)] == $past(mode_reg[wr.page]))
        else $error("locked mode change on live channel not rejected");

    a_fault_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
        s_rejected_write ##1 !wr.valid |-> s_fault_once)
        else $error("fault not a single pulse");

    a_live_accept: assert property (@(posedge core_clk) disable iff (rst)
        (wr.valid && wr.code == cmd_pwm_mode && locked_diff == 8'h00)
        |=> !comm_fault && mode_reg[$past(wr.page)] == $past(clean_data))
        else $error("live bit write not accepted");

    a_ramp_dcm: assert property (@(posedge core_clk) disable iff (rst)
        chan_ramping[0] |-> !cfg_out[0].fccm && !cfg_out[0].servo_en)
        else $error("ramping channel not in dcm");

    a_ramp_dcm_page1: assert property (@(posedge core_clk) disable iff (rst)
        chan_ramping[1] |-> !cfg_out[1].fccm && !cfg_out[1].servo_en)
        else $error("ramping channel 1 not in dcm");

    a_servo_off: assert property (@(posedge core_clk) disable iff (rst)
        !chan_on[1] |-> !cfg_out[1].servo_en)
        else $error("servo active while off");

    a_servo_off_page0: assert property (@(posedge core_clk) disable iff (rst)
        !chan_on[0] |-> !cfg_out[0].servo_en)
        else $error("servo active while channel 0 off");

    a_page1_rsvd: assert property (@(posedge core_clk) disable iff (rst)
        mode_reg[1][3:2] == 2'h0)
        else $error("page 1 drive bits not zero");

    a_drv_decode: assert property (@(posedge core_clk) disable iff (rst)
        mode_reg[0][3:2] != 2'h3 |-> cfg_out[0].drv_sel == mode_reg[0][3:2])
        else $error("gate drive code miswired");

    a_bit4_zero: assert property (@(posedge core_clk) disable iff (rst)
        !mode_reg[0][mode_bit_rsvd] && !mode_reg[1][mode_bit_rsvd])
        else $error("reserved bit 4 set");

    a_comp_write: assert property (@(posedge core_clk) disable iff (rst)
        (wr.valid && wr.code == cmd_loop_comp)
        |=> comp_reg[$past(wr.page)] == $past(wr.data) && !comm_fault)
        else $error("compensation write lost");

    a_comp_fields: assert property (@(posedge core_clk) disable iff (rst)
        {cfg_out[0].gm_code, cfg_out[0].rcomp_code} == comp_reg[0])
        else $error("compensation fields miswired");

    a_comp_fields_page1: assert property (@(posedge core_clk) disable iff (rst)
        {cfg_out[1].gm_code, cfg_out[1].rcomp_code} == comp_reg[1])
        else $error("page 1 compensation fields miswired");

    a_fault_pulse: assert property (@(posedge core_clk) disable iff (rst)
        comm_fault |=> !comm_fault || $past(wr.valid))
        else $error("fault held without a write");

    // fault only from live mode write
    a_fault_cause: assert property (@(posedge core_clk) disable iff (rst)
        comm_fault |-> $past(wr.valid && wr.code == cmd_pwm_mode && chan_on[wr.page]))
        else $error("fault without a live mode write");

endmodule

// [sim/pwm_host_model.sv]
// host model: drives register writes and readback selects of the config bank
module pwm_host_model
    import pwm_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic comm_fault,
    input wire logic [7:0] rd_data,
    output cfg_write_t wr,
    output logic rd_page,
    output logic [7:0] rd_code
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        wr = '0;
        rd_page = 1'b0;
        rd_code = 8'h00;
    end

    // one-cycle write strobe, fault sampled the cycle after
    task automatic write_reg(input logic page, input logic [7:0] code, input logic [7:0] data, output logic fault);
        @(posedge core_clk);
        wr <= '{valid: 1'b1, page: page, code: code, data: data};
        @(posedge core_clk);
        wr.valid <= 1'b0;
        #1 fault = comm_fault;
    endtask

    // readback is combinational, sampled once settled
    task automatic read_reg(input logic page, input logic [7:0] code, output logic [7:0] data);
        @(posedge core_clk);
        rd_page <= page;
        rd_code <= code;
        #1 data = rd_data;
    endtask
endmodule

// [sim/pwm_mode_comp_config_tb.sv]
// testbench: register defaults, decode, reserved masking and locked-write faults
module pwm_mode_comp_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pwm_cfg_pkg::*;
    logic core_clk, rst, rd_page, rd_hit, comm_fault, f;
    logic [7:0] rd_code, rd_data, d;
    logic [1:0] chan_on, chan_ramping;
    cfg_write_t wr;
    chan_cfg_t cfg_out [num_channels];
    int bad_count, compares;

    pwm_mode_comp_config pwm_mode_comp_config_i (.core_clk(core_clk), .rst(rst), .wr(wr), .rd_page(rd_page),
        .rd_code(rd_code), .chan_on(chan_on), .chan_ramping(chan_ramping), .rd_data(rd_data), .rd_hit(rd_hit),
        .comm_fault(comm_fault), .cfg_out(cfg_out));
    pwm_host_model pwm_host_model_i (.core_clk(core_clk), .comm_fault(comm_fault), .rd_data(rd_data), .wr(wr),
        .rd_page(rd_page), .rd_code(rd_code));

    // 50 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask
    task automatic wchk(input logic p, input logic [7:0] c, input logic [7:0] v, input logic ef);
        pwm_host_model_i.write_reg(p, c, v, f);
        check("comm_fault", {7'h00, ef}, {7'h00, f});
    endtask
    task automatic rchk(input logic p, input logic [7:0] c, input logic [7:0] ex);
        pwm_host_model_i.read_reg(p, c, d);
        check("rd_data", ex, d);
    endtask
    task automatic setch(input logic [1:0] on, input logic [1:0] ramp);
        @(posedge core_clk);
        chan_on <= on;
        chan_ramping <= ramp;
        #1;
    endtask
    task automatic tally_and_finish();
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        chan_on = 2'b00;
        chan_ramping = 2'b00;
        bad_count = 0;
        compares = 0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        rchk(1'b0, cmd_pwm_mode, 8'hC1);
        check("rd_hit", 8'h01, {7'h00, rd_hit});
        rchk(1'b1, cmd_loop_comp, 8'h70);
        rchk(1'b0, 8'h00, 8'h00);
        check("rd_hit", 8'h00, {7'h00, rd_hit});
        for (int i = 0; i < 32; i++) begin
            wchk(i[0], cmd_loop_comp, {i[2:0], i[4:0]}, 1'b0);
            check("comp", {i[2:0], i[4:0]}, {cfg_out[i[0]].gm_code, cfg_out[i[0]].rcomp_code});
        end
        for (int k = 0; k < 4; k++) begin
            wchk(1'b0, cmd_pwm_mode, {4'h0, k[1:0], 2'b00}, 1'b0);
            check("drv_sel", (k > 2) ? 8'(drv_code_max) : 8'(k), {6'h00, cfg_out[0].drv_sel});
        end
        wchk(1'b0, cmd_pwm_mode, 8'hFF, 1'b0);
        rchk(1'b0, cmd_pwm_mode, 8'hEF);
        check("decode", 8'h5B, {1'b0, cfg_out[0][14:8]});
        wchk(1'b1, cmd_pwm_mode, 8'hFF, 1'b0);
        rchk(1'b1, cmd_pwm_mode, 8'hE3);
        wchk(1'b0, cmd_pwm_mode, 8'hC1, 1'b0);
        setch(2'b01, 2'b00);
        wchk(1'b0, cmd_pwm_mode, 8'h41, 1'b1);
        @(posedge core_clk);
        #1 check("comm_fault", 8'h00, {7'h00, comm_fault});
        wchk(1'b0, cmd_pwm_mode, 8'hC3, 1'b1);
        wchk(1'b0, cmd_pwm_mode, 8'hD1, 1'b0);
        rchk(1'b0, cmd_pwm_mode, 8'hC1);
        wchk(1'b1, cmd_pwm_mode, 8'h22, 1'b0);
        rchk(1'b1, cmd_pwm_mode, 8'h22);
        wchk(1'b0, cmd_pwm_mode, 8'h80, 1'b0);
        rchk(1'b0, cmd_pwm_mode, 8'h80);
        wchk(1'b0, cmd_pwm_mode, 8'hC1, 1'b0);
        check("servo_fccm", 8'h03, {6'h00, cfg_out[0].servo_en, cfg_out[0].fccm});
        setch(2'b01, 2'b01);
        check("servo_fccm", 8'h00, {6'h00, cfg_out[0].servo_en, cfg_out[0].fccm});
        setch(2'b00, 2'b00);
        check("servo_fccm", 8'h01, {6'h00, cfg_out[0].servo_en, cfg_out[0].fccm});
        // mid-run reset brings page 1 back to its defaults
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rchk(1'b1, cmd_pwm_mode, 8'hC1);
        rchk(1'b1, cmd_loop_comp, 8'h70);
        tally_and_finish();
    end
endmodule
